//--- rtl/smm_bit_capture.sv
`timescale 1ns/100ps
`default_nettype none
module smm_bit_capture #(
  parameter int PTR_W = smm_pkg::CAP_PTR_W
) (
  // Link clock domain
  input wire logic scl_clk,
  input wire logic rst_n,
  input wire logic sda_in,
  // Gray write pointer toward the system domain
  output logic [PTR_W-1:0] wr_gray,
  // Read side, system domain
  input wire logic [PTR_W-1:0] rd_addr,
  output logic rd_bit
);
  import smm_pkg::*;
  logic [2**PTR_W-1:0] bits;
  logic [PTR_W-1:0] wr_bin;
  logic [PTR_W-1:0] next_wr;

  assign next_wr = wr_bin + 1'b1;

  // Pointer advances once per clock rise, gray copy for crossing
  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_bin <= '0;
      wr_gray <= '0;
    end else begin
      wr_bin <= next_wr;
      wr_gray <= next_wr ^ (next_wr >> 1);
    end
  end

  // Data line sampled on every rising clock edge
  always_ff @(posedge scl_clk) begin
    bits[wr_bin] <= sda_in;
  end

  assign rd_bit = bits[rd_addr];
endmodule
`default_nettype wire

//--- rtl/smm_pkg.sv
package smm_pkg;
  // ****************************************************
  // Register map and command byte values
  // ****************************************************
  localparam logic [7:0] REG_TEMP = 8'h27;
  localparam logic [7:0] REG_CFG = 8'h40;
  localparam logic [7:0] REG_INT_STATUS = 8'h41;
  localparam logic [7:0] REG_SLAVE_ADDR = 8'h42;
  localparam logic [7:0] RD_UNMAPPED = 8'hFF;

  // ****************************************************
  // Bus addresses (strap values are arbitrary)
  // ****************************************************
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [6:0] ADDR_STRAP_GND = 7'h2C;
  localparam logic [6:0] ADDR_STRAP_SDA = 7'h2D;
  localparam logic [6:0] ADDR_STRAP_SCL = 7'h2E;
  localparam logic [6:0] ADDR_STRAP_VCC = 7'h2F;

  // ****************************************************
  // Configuration fields and reset values
  // ****************************************************
  localparam int CFG_START = 0;
  localparam int CFG_ALERT_EN = 1;
  localparam int CFG_ALERT_CLR = 3;
  localparam int CFG_RATE_50HZ = 4;
  localparam int CFG_LOW_OS = 5;
  localparam int CFG_SOFT_RST = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_RW_MASK = 8'h3B;
  localparam logic [3:0] OS_RATIO_FULL = 4'h8;
  localparam logic [3:0] OS_RATIO_LOW = 4'h2;

  // ****************************************************
  // Link capture and protocol engine
  // ****************************************************
  localparam int CAP_PTR_W = 3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] RST_SYNC_INIT = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_TX, ST_IGNORE
  } smm_state_e;

  typedef enum logic [1:0] {
    STRAP_GND, STRAP_SDA, STRAP_SCL, STRAP_VCC
  } smm_strap_e;
endpackage

//--- rtl/smm_slave_if.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Write byte, read byte, read word, send byte, receive byte supported
// - Slave address is one of four, set by strap tied to GND/SDA/SCL/VCC
// - Strap level is resampled during every transaction address phase
// - Writing serial address register overrides strap until power-on reset
// - Read at alert response address with pending interrupt returns own address
// - Losing arbitration on a reply stops transmitting; alert stays low
// - Replying to alert response does not release the alert output
// - Command byte after address selects register for following data
// - Config bit 0 chooses standby or continuous conversion; bus still works
// - Config bit 1 set enables alert output, clear disables it
// - Config bit 3 releases alert, halts monitoring, keeps interrupt status
// - Config bit 4 selects conversion rate for 50Hz or 60Hz mains
// - Config bit 5 cuts oversampling 8 to 2 and selects 9-bit word format
// - Config bit 7 returns config register to defaults (address override kept) and reads back zero
// - Byte read of temperature gives signed 8-bit whole degrees
// - Word read of temperature gives 11-bit signed, upper byte first
// - With reduced oversampling, word read gives 9-bit signed value
// - Alert pin is open drain, pulled low only when asserted
// - Alert does not stop conversions; fresh data stays readable
module smm_slave_if (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Two-wire bus
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_in,
  // Alert pin
  output logic alert_out,
  output logic alert_oe,
  // Monitor core side
  input wire logic int_pending,
  input wire logic [7:0] int_status,
  output logic int_status_rd,
  input wire logic [10:0] temp_data,
  output logic conv_run,
  output logic monitor_halt,
  output logic rate_50hz,
  output logic [3:0] os_ratio
);
  import smm_pkg::*;

  // ****************************************************
  // Declarations
  // ****************************************************
  logic [1:0] rst_q;
  logic rst_n;
  logic [2:0] pins_s;
  logic scl_s, sda_s, strap_s, scl_q, sda_q;
  logic start_det, stop_det, scl_fall;
  logic [CAP_PTR_W-1:0] wr_gray_s, wr_bin_s, rd_ptr, wr_gray;
  logic bit_rise, bit_val;
  smm_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift, tx_sr, lo_byte, reg_ptr, reg_wdata, cfg;
  logic ack_phase, ack_seen, master_nack, tx_loaded, reg_we;
  logic saw_low, saw_high, diff_sda;
  smm_strap_e strap_kind;
  logic [6:0] strap_addr, active_addr, addr_over;
  logic addr_over_en, own_hit, ara_hit, byte_done, active;

  // ****************************************************
  // Reset release and pin synchronisers
  // ****************************************************
  // Reset asserted at once, released after two clocks
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_q <= RST_SYNC_INIT;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  smm_sync #(.W(3), .INIT(3'h7)) u_pin_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d({scl_clk, sda_in, addr_strap_in}),
    .q(pins_s)
  );
  assign {scl_s, sda_s, strap_s} = pins_s;

  // Previous levels for start, stop and fall detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det = scl_s && scl_q && !sda_q && sda_s;
  assign scl_fall = scl_q && !scl_s;

  // ****************************************************
  // Bit stream from the link clock domain
  // ****************************************************
  smm_bit_capture #(.PTR_W(CAP_PTR_W)) u_capture (
    .scl_clk(scl_clk),
    .rst_n(rst_n),
    .sda_in(sda_in),
    .wr_gray(wr_gray),
    .rd_addr(rd_ptr),
    .rd_bit(bit_val)
  );

  smm_sync #(.W(CAP_PTR_W)) u_ptr_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(wr_gray),
    .q(wr_gray_s)
  );

  // Gray to binary of the synchronised write pointer
  always_comb begin
    wr_bin_s[CAP_PTR_W-1] = wr_gray_s[CAP_PTR_W-1];
    for (int i = CAP_PTR_W - 2; i >= 0; i--) begin
      wr_bin_s[i] = wr_bin_s[i+1] ^ wr_gray_s[i];
    end
  end
  assign bit_rise = (rd_ptr != wr_bin_s);

  // One received bit consumed per cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (bit_rise) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // ****************************************************
  // Slave address selection
  // ****************************************************
  // Strap levels and match with the data line tracked through the address phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      saw_low <= 1'b0;
      saw_high <= 1'b0;
      diff_sda <= 1'b0;
    end else if (start_det) begin
      saw_low <= 1'b0;
      saw_high <= 1'b0;
      diff_sda <= 1'b0;
    end else if (state == ST_ADDR && !ack_phase) begin
      saw_low <= saw_low | !strap_s;
      saw_high <= saw_high | strap_s;
      diff_sda <= diff_sda | (strap_s != sda_s);
    end
  end

  // Four strap cases decoded into an address
  always_comb begin
    if (!saw_low) begin
      strap_kind = STRAP_VCC;
    end else if (!saw_high) begin
      strap_kind = STRAP_GND;
    end else if (!diff_sda) begin
      strap_kind = STRAP_SDA;
    end else begin
      strap_kind = STRAP_SCL;
    end
    case (strap_kind)
      STRAP_GND: strap_addr = ADDR_STRAP_GND;
      STRAP_SDA: strap_addr = ADDR_STRAP_SDA;
      STRAP_SCL: strap_addr = ADDR_STRAP_SCL;
      default: strap_addr = ADDR_STRAP_VCC;
    endcase
  end

  assign active_addr = addr_over_en ? addr_over : strap_addr;
  assign own_hit = (shift[7:1] == active_addr);
  assign ara_hit = (shift[7:1] == ALERT_RESP_ADDR) && shift[0]
                   && int_pending;
  assign active = (state != ST_IDLE) && (state != ST_IGNORE);
  assign byte_done = active && !start_det && !stop_det && !bit_rise
                     && scl_fall && !ack_phase && bit_cnt == BITS_PER_BYTE;

  // Upper byte of a read; temperature upper byte is sign plus 7 bits
  function automatic logic [7:0] rd_hi(input logic [7:0] ptr);
    case (ptr)
      REG_TEMP: rd_hi = temp_data[10:3];
      REG_CFG: rd_hi = cfg;
      REG_INT_STATUS: rd_hi = int_status;
      REG_SLAVE_ADDR: rd_hi = {1'b0, active_addr};
      default: rd_hi = RD_UNMAPPED;
    endcase
  endfunction

  // Second byte of a word read
  function automatic logic [7:0] rd_lo(input logic [7:0] ptr);
    if (ptr != REG_TEMP) begin
      rd_lo = rd_hi(ptr);
    end else if (cfg[CFG_LOW_OS]) begin
      rd_lo = {temp_data[2], 7'h00};
    end else begin
      rd_lo = {temp_data[2:0], 5'h00};
    end
  endfunction

  // ****************************************************
  // Protocol engine
  // ****************************************************
  // Byte framing, acknowledge slots, command pointer and replies
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= '0;
      shift <= '0;
      tx_sr <= '0;
      lo_byte <= '0;
      reg_ptr <= '0;
      reg_wdata <= '0;
      reg_we <= 1'b0;
      int_status_rd <= 1'b0;
      ack_phase <= 1'b0;
      ack_seen <= 1'b0;
      master_nack <= 1'b0;
      tx_loaded <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      reg_we <= 1'b0;
      int_status_rd <= 1'b0;
      if (start_det) begin
        state <= ST_ADDR;
        bit_cnt <= '0;
        ack_phase <= 1'b0;
        ack_seen <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
      end else if (active && bit_rise) begin
        if (ack_phase) begin
          ack_seen <= 1'b1;
          master_nack <= bit_val;
        end else begin
          shift <= {shift[6:0], bit_val};
          bit_cnt <= bit_cnt + 1'b1;
          if (state == ST_TX) begin
            tx_sr <= {tx_sr[6:0], 1'b1};
            if (tx_sr[7] && !bit_val) begin
              state <= ST_IGNORE;
              sda_oe <= 1'b0;
            end
          end
        end
      end else if (byte_done) begin
        ack_phase <= 1'b1;
        sda_oe <= (state != ST_TX);
        case (state)
          ST_ADDR: begin
            if (own_hit && shift[0]) begin
              state <= ST_TX;
              tx_sr <= rd_hi(reg_ptr);
              lo_byte <= rd_lo(reg_ptr);
              tx_loaded <= 1'b1;
              int_status_rd <= (reg_ptr == REG_INT_STATUS);
            end else if (own_hit) begin
              state <= ST_CMD;
            end else if (ara_hit) begin
              state <= ST_TX;
              tx_sr <= {active_addr, 1'b0};
              lo_byte <= RD_UNMAPPED;
              tx_loaded <= 1'b1;
            end else begin
              state <= ST_IGNORE;
              sda_oe <= 1'b0;
            end
          end
          ST_CMD: begin
            reg_ptr <= shift;
            state <= ST_WDATA;
          end
          ST_WDATA: begin
            reg_we <= 1'b1;
            reg_wdata <= shift;
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end else if (active && scl_fall && ack_phase && ack_seen) begin
        ack_phase <= 1'b0;
        ack_seen <= 1'b0;
        bit_cnt <= '0;
        tx_loaded <= 1'b0;
        if (state != ST_TX) begin
          sda_oe <= 1'b0;
        end else if (tx_loaded) begin
          sda_oe <= !tx_sr[7];
        end else if (master_nack) begin
          state <= ST_IGNORE;
          sda_oe <= 1'b0;
        end else begin
          tx_sr <= lo_byte;
          sda_oe <= !lo_byte[7];
        end
      end else if (state == ST_TX && scl_fall && !ack_phase) begin
        sda_oe <= !tx_sr[7];
      end
    end
  end
  assign sda_out = 1'b0;

  // ****************************************************
  // Registers and alert pin
  // ****************************************************
  // Configuration and serial address override
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
      addr_over <= '0;
      addr_over_en <= 1'b0;
    end else if (reg_we && reg_ptr == REG_CFG) begin
      if (reg_wdata[CFG_SOFT_RST]) begin
        cfg <= CFG_RESET;
      end else begin
        cfg <= reg_wdata & CFG_RW_MASK;
      end
    end else if (reg_we && reg_ptr == REG_SLAVE_ADDR) begin
      addr_over <= reg_wdata[6:0];
      addr_over_en <= 1'b1;
    end
  end

  assign conv_run = cfg[CFG_START];
  assign monitor_halt = cfg[CFG_ALERT_CLR];
  assign rate_50hz = cfg[CFG_RATE_50HZ];
  assign os_ratio = cfg[CFG_LOW_OS] ? OS_RATIO_LOW
                                    : OS_RATIO_FULL;

  // Open-drain alert, pulled low only while asserted
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_oe <= 1'b0;
    end else begin
      alert_oe <= int_pending && cfg[CFG_ALERT_EN]
                  && !cfg[CFG_ALERT_CLR];
    end
  end
  assign alert_out = 1'b0;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  nack_foreign_a: assert property (
    byte_done && state == ST_ADDR && !own_hit && !ara_hit
    |=> state == ST_IGNORE && !sda_oe ##1 !sda_oe)
    else $error("foreign address acknowledged");
  ara_reply_a: assert property (
    byte_done && state == ST_ADDR && !own_hit && ara_hit
    |=> state == ST_TX && tx_sr == {$past(active_addr), 1'b0})
    else $error("alert response did not return own address");
  arb_lost_a: assert property (
    state == ST_TX && bit_rise && !ack_phase && tx_sr[7] && !bit_val
    && !start_det && !stop_det
    |=> state == ST_IGNORE && !sda_oe)
    else $error("transmit continued after lost arbitration");
  alert_hold_a: assert property (
    alert_oe && int_pending && $stable(cfg) |=> alert_oe)
    else $error("alert released without clear or mask");
  alert_gate_a: assert property (
    !cfg[CFG_ALERT_EN] || cfg[CFG_ALERT_CLR] |=> !alert_oe)
    else $error("alert driven while disabled or cleared");
  soft_reset_a: assert property (
    reg_we && reg_ptr == REG_CFG && reg_wdata[CFG_SOFT_RST]
    |=> cfg == CFG_RESET && !cfg[CFG_SOFT_RST])
    else $error("soft reset did not restore defaults");
  cmd_pointer_a: assert property (
    byte_done && state == ST_CMD
    |=> reg_ptr == $past(shift) && state == ST_WDATA)
    else $error("command byte not stored as pointer");
  addr_override_a: assert property (
    reg_we && reg_ptr == REG_SLAVE_ADDR
    |=> addr_over_en && active_addr == $past(reg_wdata[6:0]))
    else $error("serial address write not in force");
  low_os_fmt_a: assert property (
    byte_done && state == ST_ADDR && own_hit && shift[0]
    && reg_ptr == REG_TEMP && cfg[CFG_LOW_OS]
    |=> lo_byte == {$past(temp_data[2]), 7'h00}
        && tx_sr == $past(temp_data[10:3]))
    else $error("9-bit temperature word malformed");

  word_read_c: cover property (
    state == ST_TX && ack_phase && ack_seen && !master_nack && !tx_loaded
    && scl_fall);
  ara_reply_c: cover property (
    byte_done && state == ST_ADDR && !own_hit && ara_hit);
  reg_write_c: cover property (reg_we && reg_ptr == REG_CFG);
endmodule
`default_nettype wire

//--- rtl/smm_sync.sv
`timescale 1ns/100ps
`default_nettype none
module smm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input and synchronised copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import smm_pkg::*;
  logic [W-1:0] meta;

  // Two flip-flop synchroniser, first stage read only by second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT; // Idle level of the pin, no false edge
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

//--- tb/smm_host.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************
// Bus host model: open-drain data, clock idles high
// ****************************************************
module smm_host (
  // Resolved data wire
  input wire logic sda,
  // Host side of the wires
  output logic scl,
  output logic sda_low
);
  localparam int H = 200; // Half bit period, slow enough for the sync
  localparam int Q = 50; // Data moves a quarter into the low phase

  // Clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Start or repeated start
  task automatic start();
    #Q;
    sda_low = 1'b0;
    #(H - Q);
    scl = 1'b1;
    #H;
    sda_low = 1'b1;
    #H;
    scl = 1'b0;
  endtask

  // Stop, leaves both wires released
  task automatic stop();
    #Q;
    sda_low = 1'b1;
    #(H - Q);
    scl = 1'b1;
    #H;
    sda_low = 1'b0;
    #H;
  endtask

  // One byte MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic hack,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #Q;
      sda_low = ~tx[i];
      #(H - Q);
      scl = 1'b1;
      #(H / 2);
      rx[i] = sda;
      #(H / 2);
      scl = 1'b0;
    end
    #Q;
    sda_low = hack;
    #(H - Q);
    scl = 1'b1;
    #(H / 2);
    ack = ~sda;
    #(H / 2);
    scl = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import smm_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic int_pending = 1'b0;
  logic [7:0] int_status = 8'h00;
  logic [10:0] temp_data = 11'h000;
  logic [1:0] strap = 2'h0;
  logic [31:0] seed = 32'h00000034;
  logic scl, sda_low, sda_out, sda_oe, alert_out, alert_oe, int_status_rd;
  logic conv_run, monitor_halt, rate_50hz, ok;
  logic [3:0] os_ratio;
  logic [15:0] v;
  logic [7:0] rx8;
  logic k8;
  logic rd_seen = 1'b0;
  wire logic sda_w;
  wire logic strap_w;
  int num_errors = 0;
  int compares = 0;

  // ****************************************************
  // Clock, wires and instances
  // ****************************************************
  always #5 sys_clk = ~sys_clk;
  assign sda_w = ~(sda_low | sda_oe); // Pull-up on the data wire
  assign strap_w = (strap == 2'h0) ? 1'b0 : (strap == 2'h1) ? sda_w :
                   (strap == 2'h2) ? scl : 1'b1;
  smm_host host_i (.sda(sda_w), .scl(scl), .sda_low(sda_low));
  smm_slave_if smm_slave_if_i (.sys_clk(sys_clk), .nrst(nrst),
    .scl_clk(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_in(strap_w), .alert_out(alert_out), .alert_oe(alert_oe),
    .int_pending(int_pending), .int_status(int_status),
    .int_status_rd(int_status_rd), .temp_data(temp_data),
    .conv_run(conv_run), .monitor_halt(monitor_halt),
    .rate_50hz(rate_50hz), .os_ratio(os_ratio));

  // Remembers the status-read pulse, which stands one cycle only
  always @(posedge sys_clk) begin
    if (int_status_rd === 1'b1) rd_seen <= 1'b1;
  end

  // ****************************************************
  // Expectations and helpers
  // ****************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction

  function automatic logic [6:0] strap_addr(input logic [1:0] s);
    case (s)
      2'h0: strap_addr = ADDR_STRAP_GND;
      2'h1: strap_addr = ADDR_STRAP_SDA;
      2'h2: strap_addr = ADDR_STRAP_SCL;
      default: strap_addr = ADDR_STRAP_VCC;
    endcase
  endfunction

  // Word readout with don't-care bits masked off
  function automatic logic [15:0] exp_word(input logic [10:0] t,
                                           input logic low);
    exp_word = low ? {t[10:3], t[2], 7'h00} : {t[10:3], t[2:0], 5'h00};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({15'h0000, seen}, {15'h0000, exp});
  endtask

  task automatic new_temp();
    seed = xs(seed);
    @(negedge sys_clk);
    temp_data = seed[10:0];
    int_status = seed[18:11];
  endtask

  // Write byte, or send byte when no data follows
  task automatic wr(input logic [6:0] a, input logic [7:0] cmd,
                    input logic [7:0] d, input logic with_data,
                    output logic ack);
    logic [7:0] rx;
    logic k;
    @(negedge sys_clk);
    host_i.start();
    host_i.xfer({a, 1'b0}, 1'b0, rx, ack);
    if (ack === 1'b1) begin
      host_i.xfer(cmd, 1'b0, rx, k);
      ack = ack & k;
      if (with_data) begin
        host_i.xfer(d, 1'b0, rx, k);
        ack = ack & k;
      end
    end
    host_i.stop();
  endtask

  // Read byte/word with a command, or receive byte without
  task automatic rd(input logic [6:0] a, input logic [7:0] cmd,
                    input logic use_cmd, input int n,
                    output logic [15:0] val, output logic ack);
    logic [7:0] rx;
    logic k;
    val = 16'h0000;
    ack = 1'b1;
    @(negedge sys_clk);
    host_i.start();
    if (use_cmd) begin
      host_i.xfer({a, 1'b0}, 1'b0, rx, k);
      ack = k;
      host_i.xfer(cmd, 1'b0, rx, k);
      host_i.start();
    end
    host_i.xfer({a, 1'b1}, 1'b0, rx, k);
    ack = ack & k;
    for (int i = 0; i < n; i++) begin
      host_i.xfer(8'hFF, (i < n - 1), rx, k);
      val = {val[7:0], rx};
    end
    host_i.stop();
  endtask

  task automatic results();
    $display("Counts: %0d errors, %0d compares", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    nrst = 1'b0;
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask

  // ****************************************************
  // Watchdog
  // ****************************************************
  initial begin
    #400000;
    num_errors++;
    results();
  end

  // ****************************************************
  // Main sequence
  // ****************************************************
  initial begin
    do_reset();
    check({sda_oe, alert_oe, conv_run, os_ratio}, 16'h0008);
    for (int s = 0; s < 4; s++) begin
      strap = s[1:0];
      wr(strap_addr(s[1:0]), REG_TEMP, 8'h00, 1'b0, ok);
      chk1(ok, 1'b1);
    end
    wr(ADDR_STRAP_GND, REG_TEMP, 8'h00, 1'b0, ok);
    chk1(ok, 1'b0);
    strap = 2'h0;
    // Start bit set in the same write as the other bits; no limit registers live in this block
    wr(ADDR_STRAP_GND, REG_CFG, 8'h33, 1'b1, ok);
    chk1(ok, 1'b1);
    check({conv_run, rate_50hz, monitor_halt, os_ratio}, 16'h0062);
    new_temp();
    rd(ADDR_STRAP_GND, REG_TEMP, 1'b1, 2, v, ok);
    check(v & 16'hFF80, exp_word(temp_data, 1'b1));
    @(negedge sys_clk);
    int_pending = 1'b1;
    repeat (3) @(negedge sys_clk);
    check({alert_oe, alert_out, sda_out}, 16'h0004);
    rd(ALERT_RESP_ADDR, 8'h00, 1'b0, 1, v, ok);
    chk1(ok, 1'b1);
    check(v, {8'h00, ADDR_STRAP_GND, 1'b0});
    chk1(alert_oe, 1'b1);
    // Lower address 0x08 wins the alert response against us
    @(negedge sys_clk);
    host_i.start();
    host_i.xfer({ALERT_RESP_ADDR, 1'b1}, 1'b0, rx8, k8);
    host_i.xfer(8'h10, 1'b0, rx8, k8);
    host_i.stop();
    check({8'h00, rx8}, 16'h0010);
    chk1(alert_oe, 1'b1);
    new_temp();
    rd(ADDR_STRAP_GND, REG_TEMP, 1'b1, 1, v, ok);
    check(v, {8'h00, temp_data[10:3]});
    chk1(rd_seen, 1'b0);
    rd(ADDR_STRAP_GND, REG_INT_STATUS, 1'b1, 1, v, ok);
    check(v, {8'h00, int_status});
    chk1(rd_seen, 1'b1);
    // Host clears the alert before polling again
    wr(ADDR_STRAP_GND, REG_CFG, 8'h3B, 1'b1, ok);
    check({alert_oe, monitor_halt}, 16'h0001);
    wr(ADDR_STRAP_GND, REG_CFG, 8'h80, 1'b1, ok);
    rd(ADDR_STRAP_GND, REG_CFG, 1'b1, 1, v, ok);
    check(v, 16'h0000);
    check({alert_oe, os_ratio}, {11'h000, 1'b0, OS_RATIO_FULL});
    wr(ADDR_STRAP_GND, REG_SLAVE_ADDR, 8'h55, 1'b1, ok);
    wr(ADDR_STRAP_GND, REG_TEMP, 8'h00, 1'b0, ok);
    chk1(ok, 1'b0);
    new_temp();
    rd(7'h55, REG_TEMP, 1'b1, 2, v, ok);
    chk1(ok, 1'b1);
    check(v & 16'hFFE0, exp_word(temp_data, 1'b0));
    do_reset();
    wr(ADDR_STRAP_GND, REG_TEMP, 8'h00, 1'b0, ok);
    chk1(ok, 1'b1);
    results();
  end
endmodule
`default_nettype wire
